// ---- hdl/icr_pkg.sv ----
// Constants for the interrupt control register block
package icr_pkg;

  // ==========================================================
  // Register map (word index on the plain register port)
  localparam logic [2:0] ADDR_GLOBAL_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_EDGE_PULLUP   = 3'h1;
  localparam logic [2:0] ADDR_EXT_CTRL      = 3'h2;
  localparam logic [2:0] ADDR_PERIPH_FLAGS  = 3'h3;
  localparam logic [2:0] ADDR_RESET_CTRL    = 3'h4;

  // ==========================================================
  // Global interrupt control fields
  localparam int GLB_HIGH_ENABLE   = 7;
  localparam int GLB_PERIPH_LOW_EN = 6;
  localparam int GLB_T0_ENABLE     = 5;
  localparam int GLB_EXT0_ENABLE   = 4;
  localparam int GLB_PORT_ENABLE   = 3;
  localparam int GLB_T0_FLAG       = 2;
  localparam int GLB_EXT0_FLAG     = 1;
  localparam int GLB_PORT_FLAG     = 0;

  // Edge, pull-up and priority control fields
  localparam int EDG_PULLUP_DISABLE = 7;
  localparam int EDG_EXT0_EDGE      = 6;
  localparam int EDG_EXT1_EDGE      = 5;
  localparam int EDG_EXT2_EDGE      = 4;
  localparam int EDG_T0_PRIORITY    = 2;
  localparam int EDG_PORT_PRIORITY  = 0;

  // External interrupt control fields
  localparam int EXT_EXT2_PRIORITY = 7;
  localparam int EXT_EXT1_PRIORITY = 6;
  localparam int EXT_EXT2_ENABLE   = 4;
  localparam int EXT_EXT1_ENABLE   = 3;
  localparam int EXT_EXT2_FLAG     = 1;
  localparam int EXT_EXT1_FLAG     = 0;

  // Peripheral flag fields
  localparam int PIR_RX_FULL  = 5;
  localparam int PIR_TX_EMPTY = 4;

  // Reset control: priority scheme enable position
  localparam int RST_PRIORITY_ENABLE = 7;

  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] EDGE_PULLUP_MASK   = 8'hf5;
  localparam logic [7:0] EXT_CTRL_MASK      = 8'hdb;
  localparam logic [7:0] PIR_SW_MASK        = 8'hcf;
  localparam logic [7:0] GLOBAL_CTRL_RESET  = 8'h00;
  localparam logic [7:0] EDGE_PULLUP_RESET  = 8'hf5;
  localparam logic [7:0] EXT_CTRL_RESET     = 8'hc0;
  localparam logic [7:0] PERIPH_FLAGS_RESET = 8'h00;

  // ==========================================================
  // Vector addresses handed to the core
  localparam logic [23:0] VECTOR_HIGH = 24'h000008;
  localparam logic [23:0] VECTOR_LOW  = 24'h000018;

  // Pin bundle: bits 2..0 external pins, bits 6..3 upper port pins
  localparam int PIN_COUNT = 7;

endpackage

// ---- hdl/icr_irq_regs.sv ----
// Interrupt control registers, flag capture and vector request logic
`timescale 1ns/1ps
module icr_irq_regs
  import icr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic [2:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdata,
  input  wire logic [2:0]  extPins,
  input  wire logic [3:0]  upperPortBPins,
  input  wire logic        portBDataRead,
  input  wire logic [7:0]  portBLatch,
  output logic      [7:0]  pullupEnable,
  input  wire logic        timerZeroOverflow,
  input  wire logic        parallelPortAccess,
  input  wire logic        conversionDone,
  input  wire logic        receiveLoaded,
  input  wire logic        receiveBufferRead,
  input  wire logic        transmitFreed,
  input  wire logic        transmitBufferWrite,
  input  wire logic        syncSerialDone,
  input  wire logic        captureCompareEvent,
  input  wire logic        timerTwoMatch,
  input  wire logic        timerOneOverflow,
  input  wire logic [7:0]  peripheralEnable,
  input  wire logic [7:0]  peripheralPriority,
  output logic             irqRequest,
  output logic      [23:0] irqVector,
  input  wire logic        irqAccept
);
  import icr_pkg::*;

  // ==========================================================
  // Helpers
  // Merge a software write under a mask, then let hardware sets win
  function automatic logic [7:0] mergeFlags(input logic [7:0] cur,
                                            input logic       wr,
                                            input logic [7:0] wdat,
                                            input logic [7:0] mask,
                                            input logic [7:0] setv);
    logic [7:0] base;
    base = wr ? ((wdat & mask) | (cur & ~mask)) : cur;
    return base | setv;
  endfunction

  // Edge detect with selectable polarity
  function automatic logic edgeHit(input logic prev,
                                   input logic cur,
                                   input logic rising);
    return rising ? (cur & ~prev) : (~cur & prev);
  endfunction

  // ==========================================================
  // Registers
  logic [7:0]           globalCtrl_reg;
  logic [7:0]           edgePullup_reg;
  logic [7:0]           extCtrl_reg;
  logic [7:0]           periphFlags_reg;
  logic                 priorityScheme_reg;
  logic [PIN_COUNT-1:0] pinMeta_reg;
  logic [PIN_COUNT-1:0] pinSyncA_reg;
  logic [PIN_COUNT-1:0] pinSyncB_reg;
  logic [PIN_COUNT-1:0] pinFilt_reg;
  logic [PIN_COUNT-1:0] pinPrev_reg;
  logic [3:0]           portSnap_reg;
  logic                 irqRequest_reg;
  logic [23:0]          irqVector_reg;
  logic [7:0]           regRdata_reg;
  logic [7:0]           pullupEnable_reg;

  // Decoded strobes and events
  logic       wrGlobal;
  logic       wrEdge;
  logic       wrExt;
  logic       wrPeriph;
  logic       wrReset;
  logic [2:0] extEdge;
  logic       portMismatch;
  logic [7:0] globalSet;
  logic [7:0] extSet;
  logic [7:0] periphSet;
  logic       acceptNow;

  // Address decode for software writes
  always_comb begin
    wrGlobal = 1'b0;
    wrEdge   = 1'b0;
    wrExt    = 1'b0;
    wrPeriph = 1'b0;
    wrReset  = 1'b0;
    if (regWrite && regAddr == ADDR_GLOBAL_CTRL) begin
      wrGlobal = 1'b1;
    end else if (regWrite && regAddr == ADDR_EDGE_PULLUP) begin
      wrEdge = 1'b1;
    end else if (regWrite && regAddr == ADDR_EXT_CTRL) begin
      wrExt = 1'b1;
    end else if (regWrite && regAddr == ADDR_PERIPH_FLAGS) begin
      wrPeriph = 1'b1;
    end else if (regWrite && regAddr == ADDR_RESET_CTRL) begin
      wrReset = 1'b1;
    end
  end

  // ==========================================================
  // Pin synchronisers: three stages, change taken when last two agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg  <= '0;
      pinSyncA_reg <= '0;
      pinSyncB_reg <= '0;
    end else if (ce) begin
      pinMeta_reg  <= {upperPortBPins, extPins};
      pinSyncA_reg <= pinMeta_reg;
      pinSyncB_reg <= pinSyncA_reg;
    end
  end

  // Filtered level per pin; a lone glitch in stage A never reaches it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinFilt_reg <= '0;
      pinPrev_reg <= '0;
    end else if (ce) begin
      pinFilt_reg <= (pinSyncA_reg & pinSyncB_reg) |
                     (pinFilt_reg & (pinSyncA_reg ^ pinSyncB_reg));
      pinPrev_reg <= pinFilt_reg;
    end
  end

  // Edge events on the external pins
  always_comb begin
    extEdge[0] = edgeHit(pinPrev_reg[0], pinFilt_reg[0],
                         edgePullup_reg[EDG_EXT0_EDGE]);
    extEdge[1] = edgeHit(pinPrev_reg[1], pinFilt_reg[1],
                         edgePullup_reg[EDG_EXT1_EDGE]);
    extEdge[2] = edgeHit(pinPrev_reg[2], pinFilt_reg[2],
                         edgePullup_reg[EDG_EXT2_EDGE]);
  end

  // Port snapshot taken when software reads the port data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      portSnap_reg <= '0;
    end else if (ce && portBDataRead) begin
      portSnap_reg <= pinFilt_reg[6:3];
    end
  end

  // Mismatch stays asserted, so the flag keeps coming back until a read
  assign portMismatch = (pinFilt_reg[6:3] != portSnap_reg);

  // ==========================================================
  // Hardware set vectors, independent of every enable
  always_comb begin
    globalSet                = '0;
    globalSet[GLB_T0_FLAG]   = timerZeroOverflow;
    globalSet[GLB_EXT0_FLAG] = extEdge[0];
    globalSet[GLB_PORT_FLAG] = portMismatch;
    extSet                   = '0;
    extSet[EXT_EXT2_FLAG]    = extEdge[2];
    extSet[EXT_EXT1_FLAG]    = extEdge[1];
    periphSet = {parallelPortAccess, conversionDone, receiveLoaded,
                 transmitFreed, syncSerialDone, captureCompareEvent,
                 timerTwoMatch, timerOneOverflow};
  end

  // ==========================================================
  // Global control: sticky flags, enables, cleared on acceptance
  assign acceptNow = irqAccept && irqRequest_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      globalCtrl_reg <= GLOBAL_CTRL_RESET;
    end else if (ce) begin
      globalCtrl_reg <= mergeFlags(globalCtrl_reg, wrGlobal, regWdata,
                                   8'hff, globalSet);
      if (acceptNow) begin
        // Only the enable that let this request through is dropped
        if (!priorityScheme_reg || irqVector_reg == VECTOR_HIGH) begin
          globalCtrl_reg[GLB_HIGH_ENABLE] <= 1'b0;
        end else begin
          globalCtrl_reg[GLB_PERIPH_LOW_EN] <= 1'b0;
        end
      end
    end
  end

  // Edge select, pull-up and priority bits; holes stay zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edgePullup_reg <= EDGE_PULLUP_RESET;
    end else if (ce && wrEdge) begin
      edgePullup_reg <= regWdata & EDGE_PULLUP_MASK;
    end
  end

  // External interrupt 1 and 2 control with sticky flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extCtrl_reg <= EXT_CTRL_RESET;
    end else if (ce) begin
      extCtrl_reg <= mergeFlags(extCtrl_reg, wrExt, regWdata,
                                EXT_CTRL_MASK, extSet);
    end
  end

  // Peripheral flags; buffer status bits ignore software writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      periphFlags_reg <= PERIPH_FLAGS_RESET;
    end else if (ce) begin
      periphFlags_reg <= mergeFlags(periphFlags_reg, wrPeriph, regWdata,
                                    PIR_SW_MASK, periphSet);
      if (receiveBufferRead && !receiveLoaded) begin
        periphFlags_reg[PIR_RX_FULL] <= 1'b0;
      end
      if (transmitBufferWrite && !transmitFreed) begin
        periphFlags_reg[PIR_TX_EMPTY] <= 1'b0;
      end
    end
  end

  // Priority scheme switch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      priorityScheme_reg <= 1'b0;
    end else if (ce && wrReset) begin
      priorityScheme_reg <= regWdata[RST_PRIORITY_ENABLE];
    end
  end

  // ==========================================================
  // Request arbitration
  logic [7:0] srcPending;
  logic [7:0] srcPriority;
  logic       corePending;
  logic       periphPending;
  logic       highPending;
  logic       lowPending;
  logic       compatReq;

  // Core sources: timer 0, ext 0..2, port change; ext 0 is always high
  always_comb begin
    srcPending  = '0;
    srcPriority = '0;
    srcPending[0]  = globalCtrl_reg[GLB_T0_FLAG] & globalCtrl_reg[GLB_T0_ENABLE];
    srcPending[1]  = globalCtrl_reg[GLB_EXT0_FLAG] & globalCtrl_reg[GLB_EXT0_ENABLE];
    srcPending[2]  = extCtrl_reg[EXT_EXT1_FLAG] & extCtrl_reg[EXT_EXT1_ENABLE];
    srcPending[3]  = extCtrl_reg[EXT_EXT2_FLAG] & extCtrl_reg[EXT_EXT2_ENABLE];
    srcPending[4]  = globalCtrl_reg[GLB_PORT_FLAG] & globalCtrl_reg[GLB_PORT_ENABLE];
    srcPriority[0] = edgePullup_reg[EDG_T0_PRIORITY];
    srcPriority[1] = 1'b1;
    srcPriority[2] = extCtrl_reg[EXT_EXT1_PRIORITY];
    srcPriority[3] = extCtrl_reg[EXT_EXT2_PRIORITY];
    srcPriority[4] = edgePullup_reg[EDG_PORT_PRIORITY];
  end

  // Pending per priority class; priority bits ignored in compatibility
  always_comb begin
    corePending   = |srcPending;
    periphPending = |(periphFlags_reg & peripheralEnable);
    compatReq     = globalCtrl_reg[GLB_HIGH_ENABLE] &
                    (corePending | (globalCtrl_reg[GLB_PERIPH_LOW_EN] &
                                    periphPending));
    highPending   = globalCtrl_reg[GLB_HIGH_ENABLE] &
                    (|(srcPending & srcPriority) |
                     |(periphFlags_reg & peripheralEnable & peripheralPriority));
    // A low request still needs the high enable, so clearing it stops all
    lowPending    = globalCtrl_reg[GLB_HIGH_ENABLE] &
                    globalCtrl_reg[GLB_PERIPH_LOW_EN] &
                    (|(srcPending & ~srcPriority) |
                     |(periphFlags_reg & peripheralEnable &
                       ~peripheralPriority));
  end

  // Registered request and vector toward the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqRequest_reg <= 1'b0;
      irqVector_reg  <= VECTOR_HIGH;
    end else if (ce) begin
      if (!priorityScheme_reg) begin
        irqRequest_reg <= compatReq & ~acceptNow;
        irqVector_reg  <= VECTOR_HIGH;
      end else begin
        irqRequest_reg <= (highPending | lowPending) & ~acceptNow;
        irqVector_reg  <= highPending ? VECTOR_HIGH : VECTOR_LOW;
      end
    end
  end

  assign irqRequest = irqRequest_reg;
  assign irqVector  = irqVector_reg;

  // ==========================================================
  // Pull-up control toward the port pads
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pullupEnable_reg <= '0;
    end else if (ce) begin
      pullupEnable_reg <= edgePullup_reg[EDG_PULLUP_DISABLE] ? 8'h00
                                                             : portBLatch;
    end
  end

  assign pullupEnable = pullupEnable_reg;

  // ==========================================================
  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_reg <= '0;
    end else if (ce) begin
      regRdata_reg <= 8'h00;
      if (regRead) begin
        if (regAddr == ADDR_GLOBAL_CTRL) begin
          regRdata_reg <= globalCtrl_reg;
        end else if (regAddr == ADDR_EDGE_PULLUP) begin
          regRdata_reg <= edgePullup_reg & EDGE_PULLUP_MASK;
        end else if (regAddr == ADDR_EXT_CTRL) begin
          regRdata_reg <= extCtrl_reg & EXT_CTRL_MASK;
        end else if (regAddr == ADDR_PERIPH_FLAGS) begin
          regRdata_reg <= periphFlags_reg;
        end else if (regAddr == ADDR_RESET_CTRL) begin
          regRdata_reg <= {priorityScheme_reg, 7'h00};
        end
      end
    end
  end

  assign regRdata = regRdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_timer_flag_set: assert property (ce && timerZeroOverflow |=>
    globalCtrl_reg[GLB_T0_FLAG]) else $error("timer0 flag not set");

  a_set_beats_clear: assert property (ce && wrGlobal &&
    !regWdata[GLB_T0_FLAG] && timerZeroOverflow |=> globalCtrl_reg[GLB_T0_FLAG])
    else $error("timer0 set lost to clear");

  a_mismatch_holds: assert property (ce && portMismatch |=>
    globalCtrl_reg[GLB_PORT_FLAG]) else $error("port flag not held");

  a_accept_drops_gie: assert property (ce && acceptNow && !priorityScheme_reg
    |=> !globalCtrl_reg[GLB_HIGH_ENABLE] && !irqRequest)
    else $error("accept did not clear enable");

  a_no_req_disabled: assert property ($past(ce) &&
    !$past(globalCtrl_reg[GLB_HIGH_ENABLE]) |-> !irqRequest)
    else $error("request with global enable off");

  a_low_vec_needs_prio: assert property (irqRequest &&
    irqVector == VECTOR_LOW |-> $past(priorityScheme_reg))
    else $error("low vector in compatibility mode");

  a_rx_read_clears: assert property (ce && receiveBufferRead && !receiveLoaded
    |=> !periphFlags_reg[PIR_RX_FULL]) else $error("receive flag not cleared");

  a_pullup_forced: assert property ($past(ce) &&
    $past(edgePullup_reg[EDG_PULLUP_DISABLE]) |-> pullupEnable == 8'h00)
    else $error("pull-ups on while disabled");

  a_holes_read_zero: assert property ($past(ce && regRead) &&
    $past(regAddr) == ADDR_EXT_CTRL |-> regRdata[5] == 1'b0 && regRdata[2] == 1'b0)
    else $error("reserved bit read as one");

  a_freeze_state: assert property (!ce |=> $stable(globalCtrl_reg) &&
    $stable(periphFlags_reg)) else $error("state moved while frozen");

endmodule

// ---- tb/icr_core_model.sv ----
// Processor core model that takes interrupt requests and records vectors
`timescale 1ns/1ps
module icr_core_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  lat,
  input  wire logic        irqRequest,
  input  wire logic [23:0] irqVector,
  output logic             irqAccept,
  output logic      [23:0] lastVector,
  output logic      [7:0]  acceptCount
);
  logic [1:0] waitCount_reg;

  // ==========================================================
  // Acceptance
  // Waits lat cycles into a request, then a one-cycle accept; the
  // pulse never repeats back to back, since a raised accept is always cleared next
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqAccept     <= 1'b0;
      lastVector    <= 24'h000000;
      acceptCount   <= 8'h00;
      waitCount_reg <= 2'h0;
    end else if (irqAccept) begin
      irqAccept     <= 1'b0;
      waitCount_reg <= 2'h0;
    end else if (irqRequest && waitCount_reg == lat) begin
      irqAccept   <= 1'b1;
      lastVector  <= irqVector;
      acceptCount <= acceptCount + 8'h01;
    end else if (irqRequest) begin
      waitCount_reg <= waitCount_reg + 2'h1;
    end else begin
      waitCount_reg <= 2'h0;
    end
  end
endmodule

// ---- tb/icr_irq_regs_tb.sv ----
// Self-checking testbench for the interrupt control registers
`timescale 1ns/1ps
module icr_irq_regs_tb;
  import icr_pkg::*;
  logic        clk, arst_n, regWrite, regRead, irqRequest, irqAccept, ce;
  logic [2:0]  regAddr, extPins;
  logic [7:0]  regWdata, regRdata, portBLatch, pullupEnable, acceptCount, periEn;
  logic [3:0]  upperPortBPins;
  logic [11:0] ev;
  logic [1:0]  lat;
  logic [23:0] irqVector, lastVector;
  int          mismatches, cmp_count;

  // ==========================================================
  // Design and core model
  icr_irq_regs icr_irq_regs_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .extPins(extPins),
    .upperPortBPins(upperPortBPins), .portBDataRead(ev[11]), .portBLatch(portBLatch),
    .pullupEnable(pullupEnable), .timerZeroOverflow(ev[0]), .parallelPortAccess(ev[1]),
    .conversionDone(ev[2]), .receiveLoaded(ev[3]), .receiveBufferRead(ev[4]),
    .transmitFreed(ev[5]), .transmitBufferWrite(ev[6]), .syncSerialDone(ev[7]),
    .captureCompareEvent(ev[8]), .timerTwoMatch(ev[9]), .timerOneOverflow(ev[10]),
    .peripheralEnable(periEn), .peripheralPriority(8'h00), .irqRequest(irqRequest),
    .irqVector(irqVector), .irqAccept(irqAccept));
  icr_core_model icr_core_model_i (
    .clk(clk), .arst_n(arst_n), .lat(lat), .irqRequest(irqRequest),
    .irqVector(irqVector), .irqAccept(irqAccept), .lastVector(lastVector),
    .acceptCount(acceptCount));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe is taken
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk("register", {16'h0, regRdata}, {16'h0, exp});
  endtask
  task automatic pulse(input logic [11:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  // Pins pass a synchroniser and filter before reaching flags
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // Clock, reset and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = 3'h0; regWdata = 8'h00;
    extPins = 3'h0; upperPortBPins = 4'h0; portBLatch = 8'h00; ev = 12'h000; lat = 2'h0;
    mismatches = 0; cmp_count = 0; ce = 1'b1; periEn = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unmapped index, unimplemented bits
    rd(ADDR_GLOBAL_CTRL, GLOBAL_CTRL_RESET);
    rd(ADDR_EDGE_PULLUP, EDGE_PULLUP_RESET);
    rd(ADDR_EXT_CTRL, EXT_CTRL_RESET);
    rd(ADDR_PERIPH_FLAGS, PERIPH_FLAGS_RESET);
    rd(ADDR_RESET_CTRL, 8'h00);
    rd(3'h5, 8'h00);
    wr(ADDR_EDGE_PULLUP, 8'hff);
    rd(ADDR_EDGE_PULLUP, 8'hf5);
    wr(ADDR_EXT_CTRL, 8'hff);
    rd(ADDR_EXT_CTRL, 8'hdb);
    wr(ADDR_EXT_CTRL, 8'hc0);
    rd(ADDR_EXT_CTRL, 8'hc0);
    // Flags set with every enable off, set beats a same-cycle clear
    pulse(12'h001);
    rd(ADDR_GLOBAL_CTRL, 8'h04);
    @(posedge clk);
    ev <= 12'h001;
    regAddr <= ADDR_GLOBAL_CTRL;
    regWdata <= 8'h00;
    regWrite <= 1'b1;
    @(posedge clk);
    ev <= 12'h000;
    regWrite <= 1'b0;
    rd(ADDR_GLOBAL_CTRL, 8'h04);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    rd(ADDR_GLOBAL_CTRL, 8'h00);
    // Clock enable low: an overflow pulse must leave no trace
    ce <= 1'b0;
    pulse(12'h001);
    ce <= 1'b1;
    rd(ADDR_GLOBAL_CTRL, 8'h00);
    // Peripheral flags: software ones clear by write, buffer ones by access
    pulse(12'h7ae);
    rd(ADDR_PERIPH_FLAGS, 8'hff);
    wr(ADDR_PERIPH_FLAGS, 8'h00);
    rd(ADDR_PERIPH_FLAGS, 8'h30);
    pulse(12'h050);
    rd(ADDR_PERIPH_FLAGS, 8'h00);
    // Pull-ups follow the latch only while not disabled
    portBLatch <= 8'ha5;
    settle();
    chk("pullups", {16'h0, pullupEnable}, 24'h0);
    wr(ADDR_EDGE_PULLUP, 8'h75);
    settle();
    chk("pullups", {16'h0, pullupEnable}, 24'ha5);
    wr(ADDR_EDGE_PULLUP, 8'hf5);
    // External edges: rising selected, then falling selected
    extPins <= 3'h7;
    settle();
    rd(ADDR_GLOBAL_CTRL, 8'h02);
    rd(ADDR_EXT_CTRL, 8'hc3);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    wr(ADDR_EXT_CTRL, 8'hc0);
    extPins <= 3'h0;
    settle();
    rd(ADDR_GLOBAL_CTRL, 8'h00);
    wr(ADDR_EDGE_PULLUP, 8'h85);
    extPins <= 3'h7;
    settle();
    rd(ADDR_EXT_CTRL, 8'hc0);
    extPins <= 3'h0;
    settle();
    rd(ADDR_EXT_CTRL, 8'hc3);
    wr(ADDR_EXT_CTRL, 8'hc0);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    // Port change keeps flagging until port data is read
    upperPortBPins <= 4'h1;
    settle();
    rd(ADDR_GLOBAL_CTRL, 8'h01);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    rd(ADDR_GLOBAL_CTRL, 8'h01);
    pulse(12'h800);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    rd(ADDR_GLOBAL_CTRL, 8'h00);
    // Compatibility mode: always the high vector, general enable dropped
    wr(ADDR_GLOBAL_CTRL, 8'ha0);
    pulse(12'h001);
    settle();
    chk("vector", lastVector, VECTOR_HIGH);
    rd(ADDR_GLOBAL_CTRL, 8'h24);
    // Priority mode, slow core: low vector, low enable dropped
    lat <= 2'h3;
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    wr(ADDR_RESET_CTRL, 8'h80);
    wr(ADDR_EDGE_PULLUP, 8'hf1);
    wr(ADDR_GLOBAL_CTRL, 8'he0);
    pulse(12'h001);
    settle();
    chk("vector", lastVector, VECTOR_LOW);
    rd(ADDR_GLOBAL_CTRL, 8'ha4);
    // Low source pending, only the high enable set: no request
    settle();
    chk("accepts", {16'h0, acceptCount}, 24'h2);
    // Low enable set but high enable clear disables all
    wr(ADDR_GLOBAL_CTRL, 8'h64);
    settle();
    chk("accepts", {16'h0, acceptCount}, 24'h2);
    // Timer-0 made high priority: taken at the high vector
    wr(ADDR_EDGE_PULLUP, 8'hf5);
    wr(ADDR_GLOBAL_CTRL, 8'ha4);
    settle();
    chk("vector", lastVector, VECTOR_HIGH);
    rd(ADDR_GLOBAL_CTRL, 8'h24);
    // Compatibility mode: a peripheral source also needs the peripheral enable
    periEn <= 8'h40;
    wr(ADDR_RESET_CTRL, 8'h00);
    wr(ADDR_GLOBAL_CTRL, 8'h80);
    pulse(12'h004);
    settle();
    chk("accepts", {16'h0, acceptCount}, 24'h3);
    wr(ADDR_GLOBAL_CTRL, 8'hc0);
    settle();
    chk("accepts", {16'h0, acceptCount}, 24'h4);
    chk("vector", lastVector, VECTOR_HIGH);
    rd(ADDR_GLOBAL_CTRL, 8'h40);
    rd(ADDR_PERIPH_FLAGS, 8'h40);
    test_done();
  end
endmodule
